// [hw/csw_pkg.sv]
// Constants, types and helper functions of the chip-select and wait decoder
// What this block does
// - Upper select covers 0x80000-0xfffff as one 512K block.
// - Upper window defaults to three waits; zero waits suits fast parts.
// - Lower select covers 0 to 512K, three waits, ignores ready; 0x7fbf.
// - Mid select zero also decodes a 256K window from 0x80000.
// - Peripheral lines five and six are selects with three waits.
// - Peripheral lines zero to three default to fifteen waits.
// - Peripheral line zero at I/O zero, each next one 0x100 higher.
// - Three-bit I/O wait code maps to 0,1,2,3,5,7,9,15 waits.
// - I/O strobe lasts 100 ns plus 25 ns per wait.
// - Flash is 256K words in eleven sectors: 16K, 8K, 8K, 32K, 7x64K.
// - Top 16K boot sector is write-protected; 8K at 0xfa000 is debugger.
// - SRAM spans 0-0x1ffff when 128K, 0-0x7ffff when 512K fitted.
// - Programmable pins default to inputs except the LED pin, bit 29; PIO_OUT_EXTRA adds others.
// - I/O space 64K and memory space 1M are decoded separately.
package csw_pkg;

  // ----------------------------------------------------------------------
  // Register offsets in I/O space and values after reset
  // ----------------------------------------------------------------------
  localparam logic [15:0] OFS_UPPER = 16'hffa0;
  localparam logic [15:0] OFS_LOWER = 16'hffa2;
  localparam logic [15:0] OFS_PBASE = 16'hffa4;
  localparam logic [15:0] OFS_MID = 16'hffa6;
  localparam logic [15:0] OFS_PMODE = 16'hffa8;
  localparam logic [15:0] RST_UPPER = 16'h80bf;
  localparam logic [15:0] RST_LOWER = 16'h7fbf;
  localparam logic [15:0] RST_PBASE = 16'h007f;
  localparam logic [15:0] RST_MID = 16'h81ff;
  localparam logic [15:0] RST_PMODE = 16'ha0bf;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int WS_LSB = 0;
  localparam int NORDY_BIT = 2;
  localparam int PIO_CS_MODE_BIT = 7;
  localparam int BOUND_LSB = 12;
  localparam int PBASE_LSB = 8;
  localparam int MID_BASE_LSB = 9;
  localparam int MID_SIZE_LSB = 8;

  // ----------------------------------------------------------------------
  // Memory map
  // ----------------------------------------------------------------------
  localparam logic [19:0] FLASH_BASE = 20'h80000;
  localparam logic [19:0] SECT32_BASE = 20'hf0000;
  localparam logic [19:0] SECT8A_BASE = 20'hf8000;
  localparam logic [19:0] DBG_BASE = 20'hfa000;
  localparam logic [19:0] BOOT_BASE = 20'hfc000;
  localparam logic [19:0] SRAM_TOP_128K = 20'h1ffff;
  localparam logic [19:0] SRAM_TOP_512K = 20'h7ffff;
  localparam logic [31:0] PIO_OUT_RST = 32'h20000000;
  localparam int NUM_PCS = 7;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int STROBE_BASE_NS = 100;
  localparam int STROBE_WAIT_NS = 25;

  typedef struct packed {
    logic [19:0] addr;
    logic is_io;
    logic wr;
    logic [15:0] wdata;
  } csw_req_type;

  // Three-bit I/O wait code to inserted waits
  function automatic logic [3:0] io_wait_states(input logic [2:0] code);
    unique case (code)
      3'h0: io_wait_states = 4'h0;
      3'h1: io_wait_states = 4'h1;
      3'h2: io_wait_states = 4'h2;
      3'h3: io_wait_states = 4'h3;
      3'h4: io_wait_states = 4'h5;
      3'h5: io_wait_states = 4'h7;
      3'h6: io_wait_states = 4'h9;
      3'h7: io_wait_states = 4'hf;
    endcase
  endfunction : io_wait_states

  // Strobe length in clocks, rounded up
  function automatic logic [5:0] strobe_cycles(input logic [3:0] waits);
    int ps;
    ps = (STROBE_BASE_NS + STROBE_WAIT_NS * int'(waits)) * 1000;
    strobe_cycles = 6'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction : strobe_cycles

  // Sector index counted from the bottom of flash, 0..10
  function automatic logic [3:0] flash_sector(input logic [19:0] a);
    if (a >= BOOT_BASE) flash_sector = 4'ha;
    else if (a >= DBG_BASE) flash_sector = 4'h9;
    else if (a >= SECT8A_BASE) flash_sector = 4'h8;
    else if (a >= SECT32_BASE) flash_sector = 4'h7;
    else flash_sector = {1'b0, a[18:16]};
  endfunction : flash_sector

endpackage : csw_pkg

// [hw/csw_wait_timer.sv]
// Strobe length counter with optional external ready
`timescale 1ns/1ps
module csw_wait_timer (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Control
  input wire logic i_start,
  input wire logic [5:0] i_cycles,
  input wire logic i_use_rdy,
  input wire logic i_rdy,
  // Status
  output logic o_busy,
  output logic o_last,
  output logic o_done
);
  logic [5:0] cnt_q;
  logic busy_q;
  logic done_q;
  logic use_rdy_q;

  // Ready use is latched at the start: the request may change while busy
  assign o_last = busy_q && (cnt_q == 6'h0) && (!use_rdy_q || i_rdy);
  assign o_busy = busy_q;
  assign o_done = done_q;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_q <= 6'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      use_rdy_q <= 1'b0;
    end else if (i_ce) begin
      done_q <= o_last;
      if (i_start) begin
        cnt_q <= i_cycles - 6'h1;
        busy_q <= 1'b1;
        use_rdy_q <= i_use_rdy;
      end else if (o_last) begin
        busy_q <= 1'b0;
      end else if (busy_q && cnt_q != 6'h0) begin
        cnt_q <= cnt_q - 6'h1;
      end
    end
  end

  chk_strobe_min_len: assert property (@(posedge i_mclk)
    disable iff (!i_rst_n) i_ce && i_start |=> !o_done)
    else $error("done came in the cycle after start");

endmodule : csw_wait_timer

// [hw/csw_decoder.sv]
// Chip-select decoder and wait-state generator, top level
`timescale 1ns/1ps
module csw_decoder #(
  parameter bit SRAM_512K = 1'b1,
  parameter logic [31:0] PIO_OUT_EXTRA = 32'h0
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // CPU bus request
  input wire logic i_req_valid,
  input wire csw_pkg::csw_req_type i_req,
  output logic o_req_ready,
  output logic o_done,
  output logic [15:0] o_rdata,
  // External ready pin
  input wire logic i_ext_rdy,
  // Chip selects, active low
  output logic o_upper_memory_select_n,
  output logic o_lower_memory_select_n,
  output logic o_mid_memory_select_zero_n,
  output logic [6:0] o_peripheral_select_lines_n,
  // Flash and pin status
  output logic [3:0] o_flash_sector,
  output logic o_debugger_sector,
  output logic o_boot_write_blocked,
  output logic [31:0] o_pio_dir_out
);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [15:0] upper_q, lower_q, pbase_q, mid_q, pmode_q;
  logic rdy_meta_q, rdy_sync_q;
  logic [3:0] sect_q;
  logic dbg_q, blocked_q;
  logic [15:0] rdata_q;
  logic [9:0] sel_n_q;
  logic [31:0] pio_q;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire [19:0] a = i_req.addr;
  wire [15:0] ioa = i_req.addr[15:0];
  wire is_mem = !i_req.is_io;
  wire [19:0] sram_top = SRAM_512K ? csw_pkg::SRAM_TOP_512K
                                   : csw_pkg::SRAM_TOP_128K;
  wire hit_upper = is_mem &&
    (a[19:16] >= upper_q[csw_pkg::BOUND_LSB +: 4]);
  wire hit_lower = is_mem && (a <= sram_top) &&
    (a[19:16] <= lower_q[csw_pkg::BOUND_LSB +: 4]);
  wire [19:0] mid_base = {mid_q[15:csw_pkg::MID_BASE_LSB], 13'h0};
  wire [6:0] mid_code = pmode_q[csw_pkg::MID_SIZE_LSB +: 7];
  // Window size is 8K shifted by the highest set size bit
  wire [19:0] mid_size = mid_code[6] ? 20'h80000 : mid_code[5] ? 20'h40000 :
    mid_code[4] ? 20'h20000 : mid_code[3] ? 20'h10000 :
    mid_code[2] ? 20'h08000 : mid_code[1] ? 20'h04000 : 20'h02000;
  wire hit_mid = is_mem && (a >= mid_base) &&
    (a < mid_base + mid_size);
  wire boot_write = is_mem && i_req.wr &&
    (a >= csw_pkg::BOOT_BASE);
  wire hit_reg = i_req.is_io && (ioa >= csw_pkg::OFS_UPPER) &&
    (ioa <= csw_pkg::OFS_PMODE) && !ioa[0];
  wire [7:0] pcs_blk = ioa[15:8] - pbase_q[csw_pkg::PBASE_LSB +: 8];
  wire pcs_cs_mode = pmode_q[csw_pkg::PIO_CS_MODE_BIT];
  logic [6:0] hit_pcs;
  always_comb begin
    for (int i = 0; i < csw_pkg::NUM_PCS; i++) begin
      hit_pcs[i] = i_req.is_io && !hit_reg &&
        (pcs_blk == 8'(i));
    end
    hit_pcs[4] = 1'b0;
    hit_pcs[5] = hit_pcs[5] && pcs_cs_mode;
    hit_pcs[6] = hit_pcs[6] && pcs_cs_mode;
  end

  // ----------------------------------------------------------------------
  // Wait selection, first match wins
  // ----------------------------------------------------------------------
  wire pcs_low = |hit_pcs[3:0];
  wire [3:0] ws_pcs_low = csw_pkg::io_wait_states(pbase_q[2:0]);
  wire [3:0] ws_pcs_high = {2'b00, pmode_q[1:0]};
  wire [3:0] ws_upper = {2'b00, upper_q[1:0]};
  wire [3:0] ws_lower = {2'b00, lower_q[1:0]};
  wire [3:0] ws_mid = {2'b00, mid_q[1:0]};
  wire [3:0] waits = hit_reg ? 4'h0 : hit_upper ? ws_upper :
    hit_lower ? ws_lower : hit_mid ? ws_mid :
    pcs_low ? ws_pcs_low : (|hit_pcs[6:5]) ? ws_pcs_high : 4'h0;
  wire [15:0] cfg_sel = hit_upper ? upper_q : hit_lower ? lower_q :
    hit_mid ? mid_q : pcs_low ? pbase_q : pmode_q;
  wire use_rdy = !hit_reg && !cfg_sel[csw_pkg::NORDY_BIT];
  wire [5:0] cycles = csw_pkg::strobe_cycles(waits);

  wire busy, last;
  wire take = i_req_valid && o_req_ready && i_ce;
  assign o_req_ready = !busy;

  csw_wait_timer csw_wait_timer_inst (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_start(take),
    .i_cycles(cycles),
    .i_use_rdy(use_rdy),
    .i_rdy(rdy_sync_q),
    .o_busy(busy),
    .o_last(last),
    .o_done(o_done)
  );

  wire [9:0] sel_n_d = ~{hit_upper && !boot_write, hit_lower, hit_mid,
                         hit_pcs};

  // ----------------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------------
  wire [15:0] reg_read = (ioa == csw_pkg::OFS_UPPER) ? upper_q :
    (ioa == csw_pkg::OFS_LOWER) ? lower_q :
    (ioa == csw_pkg::OFS_PBASE) ? pbase_q :
    (ioa == csw_pkg::OFS_MID) ? mid_q : pmode_q;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rdy_meta_q <= 1'b0;
      rdy_sync_q <= 1'b0;
    end else if (i_ce) begin
      rdy_meta_q <= i_ext_rdy;
      rdy_sync_q <= rdy_meta_q;
    end
  end

  // Selects stay low from the take until the strobe ends
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sel_n_q <= 10'h3ff;
    end else if (i_ce) begin
      if (take) sel_n_q <= sel_n_d;
      else if (last) sel_n_q <= 10'h3ff;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      upper_q <= csw_pkg::RST_UPPER;
      lower_q <= csw_pkg::RST_LOWER;
      pbase_q <= csw_pkg::RST_PBASE;
      mid_q <= csw_pkg::RST_MID;
      pmode_q <= csw_pkg::RST_PMODE;
    end else if (i_ce && take && hit_reg && i_req.wr) begin
      unique case (ioa)
        csw_pkg::OFS_UPPER: upper_q <= i_req.wdata;
        csw_pkg::OFS_LOWER: lower_q <= i_req.wdata;
        csw_pkg::OFS_PBASE: pbase_q <= i_req.wdata;
        csw_pkg::OFS_MID: mid_q <= i_req.wdata;
        default: pmode_q <= i_req.wdata;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rdata_q <= 16'h0;
      sect_q <= 4'h0;
      dbg_q <= 1'b0;
      blocked_q <= 1'b0;
      pio_q <= csw_pkg::PIO_OUT_RST | PIO_OUT_EXTRA;
    end else if (i_ce && take) begin
      rdata_q <= hit_reg && !i_req.wr ? reg_read : 16'h0;
      sect_q <= hit_upper ? csw_pkg::flash_sector(a) : 4'h0;
      dbg_q <= hit_upper && (a >= csw_pkg::DBG_BASE) &&
        (a < csw_pkg::BOOT_BASE);
      blocked_q <= boot_write;
    end
  end

  assign {o_upper_memory_select_n, o_lower_memory_select_n,
          o_mid_memory_select_zero_n, o_peripheral_select_lines_n} = sel_n_q;
  assign o_rdata = rdata_q;
  assign o_flash_sector = sect_q;
  assign o_debugger_sector = dbg_q;
  assign o_boot_write_blocked = blocked_q;
  assign o_pio_dir_out = pio_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  chk_upper_window: assert property (take && !i_req.is_io &&
    a >= 20'h80000 && !i_req.wr && upper_q == 16'h80bf
    |=> !o_upper_memory_select_n)
    else $error("upper select missing in top half");
  chk_upper_three_wait: assert property (take && hit_upper &&
    upper_q == 16'h80bf |-> cycles == 6'd22 ##1 (!o_done)[*8] ##1 !o_done)
    else $error("upper strobe ended too early");
  chk_lower_window: assert property (take && !i_req.is_io &&
    a > sram_top |=> o_lower_memory_select_n)
    else $error("lower select outside SRAM");
  chk_lower_cfg: assert property (take && hit_lower &&
    lower_q == 16'h7fbf |-> !use_rdy && waits == 4'h3)
    else $error("lower window wait setup wrong");
  chk_mid_window: assert property (take && !i_req.is_io &&
    a >= 20'h80000 && a < 20'hc0000 && mid_q == 16'h81ff &&
    pmode_q == 16'ha0bf |=> !o_mid_memory_select_zero_n)
    else $error("mid window missed");
  chk_pcs_spacing: assert property (take && i_req.is_io &&
    ioa[15:8] == 8'h02 && pbase_q == 16'h007f
    |=> !o_peripheral_select_lines_n[2])
    else $error("peripheral line two not at 0x200");
  chk_pcs_fifteen: assert property (take && pcs_low &&
    pbase_q[2:0] == 3'h7 |-> cycles == 6'd60)
    else $error("fifteen waits not 475 ns");
  chk_pcs_five_six: assert property (take && (|hit_pcs[6:5]) &&
    pmode_q[1:0] == 2'h3 |-> cycles == 6'd22)
    else $error("peripheral five/six waits wrong");
  chk_io_mem_split: assert property (take && i_req.is_io |=>
    o_upper_memory_select_n && o_lower_memory_select_n)
    else $error("memory select on I/O cycle");
  chk_cs_held: assert property (!o_lower_memory_select_n && !last
    |=> !o_lower_memory_select_n)
    else $error("select dropped mid-cycle");
  chk_boot_protect: assert property (take && boot_write
    |=> o_upper_memory_select_n && o_boot_write_blocked)
    else $error("boot sector write reached flash");
  chk_sector_top: assert property (take && hit_upper &&
    a >= 20'hfc000 |=> o_flash_sector == 4'ha)
    else $error("boot sector index wrong");
  chk_pio_default: assert property (
    $rose(i_rst_n) |-> o_pio_dir_out[29])
    else $error("LED pin not output after reset");

  cov_flash_read: cover property (take && hit_upper && !i_req.wr ##[1:30]
    o_done);
  cov_sram_write: cover property (take && hit_lower && i_req.wr);
  cov_pcs_slow: cover property (take && pcs_low ##[1:80] o_done);
  cov_reg_write: cover property (take && hit_reg && i_req.wr);

endmodule : csw_decoder

// [tb/csw_far_side_model.sv]
// Behavioural far side: memory and peripheral chips sharing the ready pin
`timescale 1ns/1ps
module csw_far_side_model (
  // Clock and mode
  input wire logic i_mclk,
  input wire logic i_slow,
  // Chip selects from the decoder, active low
  input wire logic i_upper_memory_select_n,
  input wire logic i_lower_memory_select_n,
  input wire logic i_mid_memory_select_zero_n,
  input wire logic [6:0] i_peripheral_select_lines_n,
  // Shared ready line
  output logic o_ext_rdy
);
  logic any_sel;
  int held_q;

  assign any_sel = !(i_upper_memory_select_n & i_lower_memory_select_n &
    i_mid_memory_select_zero_n & (&i_peripheral_select_lines_n));

  always @(posedge i_mclk) begin
    held_q <= any_sel ? held_q + 1 : 0;
  end

  // Pulled up when no chip is selected; a slow chip holds it low for a while
  assign o_ext_rdy = !any_sel || !i_slow || (held_q >= 40);
endmodule : csw_far_side_model

// [tb/csw_decoder_tb.sv]
// Self-checking testbench for the chip-select and wait decoder
`timescale 1ns/1ps
module csw_decoder_tb;
  logic i_mclk, i_rst_n, i_ce, i_req_valid, i_ext_rdy, slow;
  csw_pkg::csw_req_type i_req;
  logic o_req_ready, o_done, o_upper_n, o_lower_n, o_mid_n, o_debugger_sector;
  logic o_boot_write_blocked;
  logic [6:0] o_pcs_n;
  logic [15:0] o_rdata, rback;
  logic bsy;
  logic [3:0] o_flash_sector;
  logic [31:0] o_pio_dir_out;
  logic [9:0] sel;
  int fail_count, cmp_count, cyc, n, stall;
  int wt [8] = '{0, 1, 2, 3, 5, 7, 9, 15};
  logic [15:0] ofs [5] = '{16'hffa0, 16'hffa2, 16'hffa4, 16'hffa6, 16'hffa8};
  logic [15:0] rst [5] = '{16'h80bf, 16'h7fbf, 16'h007f, 16'h81ff, 16'ha0bf};
  logic [19:0] sa [5] = '{20'h80000, 20'hf0000, 20'hf8000, 20'hfa000,
    20'hfc000};
  logic [3:0] se [5] = '{4'h0, 4'h7, 4'h8, 4'h9, 4'ha};
  int pl [6] = '{0, 1, 2, 3, 5, 6};

  csw_decoder csw_decoder_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_req_ready(o_req_ready), .o_done(o_done), .o_rdata(o_rdata),
    .i_ext_rdy(i_ext_rdy), .o_upper_memory_select_n(o_upper_n),
    .o_lower_memory_select_n(o_lower_n),
    .o_mid_memory_select_zero_n(o_mid_n),
    .o_peripheral_select_lines_n(o_pcs_n),
    .o_flash_sector(o_flash_sector), .o_debugger_sector(o_debugger_sector),
    .o_boot_write_blocked(o_boot_write_blocked),
    .o_pio_dir_out(o_pio_dir_out));

  csw_far_side_model csw_far_side_model_inst (.i_mclk(i_mclk),
    .i_slow(slow), .i_upper_memory_select_n(o_upper_n),
    .i_lower_memory_select_n(o_lower_n),
    .i_mid_memory_select_zero_n(o_mid_n),
    .i_peripheral_select_lines_n(o_pcs_n), .o_ext_rdy(i_ext_rdy));

  // ------------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      conclude();
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic int ncyc(input int w);
    return ((100 + 25 * w) * 1000 + 7999) / 8000;
  endfunction : ncyc

  // Called just after an edge; counts edges from take to completion
  task automatic acc(input logic [19:0] a, input logic io, input logic w,
                     input logic [15:0] d);
    i_req = '{addr: a, is_io: io, wr: w, wdata: d};
    i_req_valid = 1'b1;
    // Hold the request while a cycle is still in progress
    while (o_req_ready !== 1'b1) begin
      @(posedge i_mclk);
      #1;
    end
    @(posedge i_mclk);
    #1;
    i_req_valid = 1'b0;
    sel = {o_upper_n, o_lower_n, o_mid_n, o_pcs_n};
    bsy = o_req_ready;
    n = 0;
    // A nonzero stall holds the clock enable low for that many edges
    i_ce = (stall == 0);
    while (o_done !== 1'b1 && n < 200) begin
      @(posedge i_mclk);
      #1;
      n++;
      i_ce = (n >= stall);
    end
    rback = o_rdata;
  endtask : acc

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_req_valid = 1'b0;
    i_req = '0;
    slow = 1'b0;
    repeat (8) @(posedge i_mclk);
    #1;
    i_rst_n = 1'b1;
    @(posedge i_mclk);
    #1;
    chk("pio_dir", 32'h20000000, o_pio_dir_out);
    chk("idle_sel", 10'h3ff, {o_upper_n, o_lower_n, o_mid_n, o_pcs_n});
    for (int i = 0; i < 5; i++) begin
      acc({4'h0, ofs[i]}, 1'b1, 1'b0, 16'h0);
      chk("reg_reset", rst[i], rback);
      chk("reg_cycles", ncyc(0), n);
      chk("reg_no_sel", 10'h3ff, sel);
      chk("reg_busy", 1'b0, bsy);
    end
    $display("test register_reset done");

    acc({4'h0, 16'hffa0}, 1'b1, 1'b1, 16'h80bf);
    acc(20'h80000, 1'b0, 1'b0, 16'h0);
    chk("flash_sel", {3'b010, 7'h7f}, sel);
    chk("flash_cycles", ncyc(3), n);
    acc(20'hc0000, 1'b0, 1'b0, 16'h0);
    chk("flash_hi_sel", {3'b011, 7'h7f}, sel);
    for (int i = 0; i < 5; i++) begin
      acc(sa[i], 1'b0, 1'b0, 16'h0);
      chk("sector", se[i], o_flash_sector);
      chk("dbg_flag", i == 3, o_debugger_sector);
    end
    acc(20'hfc000, 1'b0, 1'b1, 16'h1234);
    chk("boot_wr_sel", 10'h3ff, sel);
    chk("boot_blocked", 1'b1, o_boot_write_blocked);
    acc({4'h0, 16'hffa0}, 1'b1, 1'b1, 16'h80bc);
    acc(20'h90000, 1'b0, 1'b0, 16'h0);
    chk("flash_zero_wait", ncyc(0), n);
    acc({4'h0, 16'hffa0}, 1'b1, 1'b1, 16'h80bf);
    $display("test flash_window done");

    slow = 1'b1;
    acc(20'h7ffff, 1'b0, 1'b0, 16'h0);
    chk("sram_top_sel", {3'b101, 7'h7f}, sel);
    chk("sram_cycles", ncyc(3), n);
    acc(20'h00100, 1'b0, 1'b0, 16'h0);
    chk("mem_not_io", {3'b101, 7'h7f}, sel);
    slow = 1'b0;
    $display("test sram_window done");

    for (int i = 0; i < 6; i++) begin
      acc(20'h00002 + 20'(pl[i] * 256), 1'b1, 1'b0, 16'h0);
      chk("pcs_sel", {3'b111, ~(7'h01 << pl[i])}, sel);
      chk("pcs_cycles", ncyc(pl[i] < 4 ? 15 : 3), n);
    end
    acc(20'h00402, 1'b1, 1'b0, 16'h0);
    chk("pcs_four_unused", 10'h3ff, sel);
    chk("unmapped_cycles", ncyc(0), n);
    acc({4'h0, 16'hffa8}, 1'b1, 1'b1, 16'ha03f);
    acc(20'h00502, 1'b1, 1'b0, 16'h0);
    chk("pcs_five_off", 10'h3ff, sel);
    acc({4'h0, 16'hffa8}, 1'b1, 1'b1, 16'ha0bf);
    $display("test peripheral_lines done");

    for (int c = 0; c < 8; c++) begin
      acc({4'h0, 16'hffa4}, 1'b1, 1'b1, 16'h0078 | 16'(c));
      acc({4'h0, 16'hffa4}, 1'b1, 1'b0, 16'h0);
      chk("pbase_rw", 16'h0078 | 16'(c), rback);
      acc(20'h00300, 1'b1, 1'b0, 16'h0);
      chk("wait_code", ncyc(wt[c]), n);
    end
    acc({4'h0, 16'hffa4}, 1'b1, 1'b1, 16'h0078);
    slow = 1'b1;
    acc(20'h00300, 1'b1, 1'b0, 16'h0);
    chk("rdy_extend", 32'd43, n);
    slow = 1'b0;
    $display("test wait_codes done");

    i_rst_n = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    i_rst_n = 1'b1;
    @(posedge i_mclk);
    #1;
    stall = 4;
    acc({4'h0, 16'hffa4}, 1'b1, 1'b0, 16'h0);
    stall = 0;
    chk("rst_pbase", 16'h007f, rback);
    chk("ce_freeze", ncyc(0) + 4, n);
    acc({4'h0, 16'hffa4}, 1'b1, 1'b1, 16'h007f);
    $display("test reset_and_enable done");
    conclude();
  end
endmodule : csw_decoder_tb
